// ==== pkg/dispatch_pkg.sv ====
package dispatch_pkg;
  // Front end widths
  localparam int unsigned FETCH_BYTES = 16;
  localparam int unsigned DECODE_MAX_BYTES = 24;
  localparam int unsigned DECODE_WIDTH = 2;
  localparam int unsigned PREFIX_LIMIT = 3;
  localparam int unsigned MSEQ_BUBBLE_MIN = 3;
  localparam int unsigned MSEQ_BUBBLE_MAX = 7;
  localparam int unsigned PREFIX_BUBBLE = 2;
  localparam int unsigned BRANCH_BUBBLE = 1;
  // Structure sizes
  localparam int unsigned ROB_SIZE = 72;
  localparam int unsigned STORE_BUF = 16;
  localparam int unsigned INT_RS_SIZE = 12;
  localparam int unsigned MEM_RS_SIZE = 12;
  localparam int unsigned VEC_RS_SIZE = 20;
  localparam int unsigned SAB_RESERVED = 2;
  localparam int unsigned THREADS = 4;
  // Latencies
  localparam int unsigned LAT_INT_LOAD = 4;
  localparam int unsigned LAT_VEC_LOAD = 5;
  localparam int unsigned LAT_SIMPLE = 1;
  localparam int unsigned LAT_MUL_SHORT = 3;
  localparam int unsigned LAT_MUL_LONG = 5;
  localparam int unsigned LAT_FORWARD = 2;
  localparam int unsigned LINE_BYTES = 64;
  localparam int unsigned CACHE_READS = 2;
  localparam int unsigned CACHE_WRITES = 1;
  localparam int unsigned STORE_COMMIT_RATE = 1;

  typedef enum logic [3:0] {
    OP_ALU = 4'h0, OP_MUL = 4'h1, OP_LOAD = 4'h2, OP_STA = 4'h3,
    OP_VLOAD = 4'h4, OP_PREF = 4'h5, OP_VEC = 4'h6, OP_VSTD = 4'h7,
    OP_V2I = 4'h8, OP_VSPEC = 4'h9
  } op_class_t;

  typedef enum logic [1:0] {
    FE_RUN = 2'h0, FE_BUBBLE = 2'h1
  } fe_state_t;
endpackage

// ==== verification/dispatch_checker.sv ====
`timescale 1ns/10ps
module dispatch_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Front end
  input wire logic [4:0] fetch_bytes,
  input wire logic fetch_take,
  input wire logic [4:0] fetch_take_bytes,
  input wire logic [1:0] decode_take,
  input wire logic [4:0] inst0_len,
  input wire logic [4:0] inst1_len,
  input wire logic [3:0] inst0_prefixes,
  input wire logic inst0_microcoded,
  input wire logic taken_branch,
  input wire logic [3:0] uop0_class,
  // Back end
  input wire logic [1:0] alloc_count_q,
  input wire logic [2:0] result_latency_q,
  input wire logic retire_store,
  input wire logic store_commit_q,
  input wire logic fwd_youngest,
  input wire logic fwd_size_ok,
  input wire logic fwd_contained,
  input wire logic fwd_request,
  input wire logic fwd_valid_q,
  input wire logic [1:0] mem_dispatch_q,
  input wire logic [1:0] dcache_reads_q,
  input wire logic [6:0] rob_used_q
);
  import dispatch_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////////
  a_take_bytes_cap: assert property (fetch_take_bytes == ((fetch_bytes > 5'h10) ? 5'h10 : fetch_bytes))
    else $error("fetch take bytes not capped at sixteen");
  a_pair_limit: assert property (decode_take == 2'h2 |->
    ({1'h0, inst0_len} + {1'h0, inst1_len} <= 6'h18) && !inst0_microcoded)
    else $error("pair decoded beyond length or microcode limit");
  a_alloc_copy: assert property (fetch_take |=> alloc_count_q == $past(decode_take))
    else $error("allocate count differs from decode count");
  a_mseq_bubble: assert property (fetch_take && inst0_microcoded |=> !fetch_take [*3])
    else $error("microcode bubble shorter than three cycles");
  a_prefix_bubble: assert property (fetch_take && inst0_prefixes > 4'h3 |=> !fetch_take [*2])
    else $error("prefix bubble missing");
  a_branch_bubble: assert property (fetch_take && taken_branch |=> !fetch_take)
    else $error("taken branch delay missing");
  a_rob_cap: assert property (rob_used_q <= 7'h48)
    else $error("reorder occupancy above capacity");
  a_commit_next: assert property (retire_store |=> store_commit_q)
    else $error("retired store not committed next cycle");
  a_commit_idle: assert property (!retire_store |=> !store_commit_q)
    else $error("store committed without retirement");
  a_fwd_timing: assert property (fwd_request && fwd_youngest && fwd_size_ok && fwd_contained |-> ##2 fwd_valid_q)
    else $error("forward not valid two cycles after request");
  a_fwd_refuse: assert property (fwd_request && !(fwd_youngest && fwd_size_ok && fwd_contained)
    |-> ##2 !fwd_valid_q)
    else $error("forward given without meeting restrictions");
  a_load_latency: assert property (fetch_take && uop0_class == OP_LOAD |=> result_latency_q == 3'h4)
    else $error("integer load latency not four");
  a_port_limits: assert property (mem_dispatch_q != 2'h3 && dcache_reads_q != 2'h3)
    else $error("memory station or cache read count above two");
endmodule // dispatch_checker
bind ooo_core_dispatch_scheduler dispatch_checker chk_u (.*);

// ==== verification/fetch_source_model.sv ====
`timescale 1ns/10ps
module fetch_source_model (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Offer from the bench
  input wire logic [3:0] want_ready,
  input wire logic [4:0] want_bytes,
  // Toward the core
  output logic [3:0] fetch_ready,
  output logic [4:0] fetch_bytes
);
  // Registered so the offer changes only just after an edge
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fetch_ready <= 4'h0;
      fetch_bytes <= 5'h00;
    end else begin
      fetch_ready <= want_ready;
      // No thread offers: the byte lines are not held, so they toggle
      fetch_bytes <= (want_ready == 4'h0) ? ~fetch_bytes : want_bytes;
    end
  end
endmodule // fetch_source_model

// ==== verification/tb_top.sv ====
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_errors++; $display("mismatch at %0t: got %0h want %0h", $time, a, b); end end
module tb_top;
  import dispatch_pkg::*;
  logic clk = 1'h0;
  logic nrst = 1'h0;
  logic [3:0] thread_awake, want_ready, fetch_ready, inst0_prefixes, uop0_class, uop1_class, thread_stall;
  logic [4:0] want_bytes, fetch_bytes, inst0_len, inst1_len, fetch_take_bytes;
  logic [2:0] mseq_flow_len, result_latency_q;
  logic [1:0] inst_count, retire_count, retire_tid, fetch_grant_tid, decode_take, alloc_count_q, alloc_tid_q;
  logic [1:0] int0_dispatch_q, int1_dispatch_q, mem_dispatch_q, vec0_dispatch_q, vec1_dispatch_q, dcache_reads_q;
  logic inst0_microcoded, inst0_aligned, taken_branch, uop_mul_wide, fetch_take, retire_store, store_commit_q;
  logic int_load_issue_q, fwd_youngest, fwd_size_ok, fwd_contained, fwd_request, fwd_valid_q, dcache_write_q;
  logic [6:0] rob_used_q;
  int n_errors = 0;
  int checked = 0;
  int cycles = 0;
  ////////////////////////////////////////////////////////////////////////////////
  always #20 clk = ~clk;
  ooo_core_dispatch_scheduler dut_u (.*);
  fetch_source_model src_u (.*);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("checked %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Generous ceiling; the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      give_verdict;
    end
  end
  task automatic step;
    @(posedge clk);
    #1;
  endtask
  task automatic plain;
    {inst_count, inst0_len, inst1_len, inst0_prefixes} = {2'h2, 5'h04, 5'h04, 4'h0};
    {inst0_microcoded, mseq_flow_len, inst0_aligned, taken_branch, uop_mul_wide} = {1'h0, 3'h0, 1'h1, 1'h0, 1'h0};
    {uop0_class, uop1_class, retire_count, retire_tid, retire_store} = {OP_ALU, OP_ALU, 2'h0, 2'h0, 1'h0};
    {fwd_youngest, fwd_size_ok, fwd_contained, fwd_request} = 4'h0;
    want_bytes = 5'h10;
  endtask
  // Reset drains every structure, so each scenario starts from empty
  task automatic restart(input logic [3:0] awake, input logic [3:0] ready);
    step;
    nrst = 1'h0;
    thread_awake = awake;
    want_ready = ready;
    plain;
    repeat (4) step;
    nrst = 1'h1;
    step;
    step;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_fetch_decode;
    restart(4'h1, 4'h1);
    want_bytes = 5'h14;
    step;
    step;
    `CHK(fetch_take_bytes, 5'h10)
    want_bytes = 5'h0a;
    {inst0_len, inst1_len} = {5'h0c, 5'h0c};
    step;
    step;
    `CHK(fetch_take_bytes, 5'h0a)
    `CHK(decode_take, 2'h2)
    step;
    `CHK(alloc_count_q, 2'h2)
    inst1_len = 5'h0d;
    #5;
    `CHK(decode_take, 2'h1)
    step;
    {inst1_len, inst0_microcoded} = {5'h04, 1'h1};
    #5;
    `CHK(decode_take, 2'h1)
  endtask
  // Counts idle cycles after one special instruction is taken
  task automatic t_bubble(input logic [3:0] pf, input logic mc, input logic [2:0] fl, input logic al,
    input logic br, input int exp);
    int n;
    restart(4'h1, 4'h1);
    {inst0_prefixes, inst0_microcoded, mseq_flow_len, inst0_aligned, taken_branch} = {pf, mc, fl, al, br};
    step;
    plain;
    n = 0;
    #5;
    while (fetch_take !== 1'h1 && n < 20) begin
      n++;
      step;
      #5;
    end
    `CHK(n, exp)
  endtask
  task automatic t_rr(input logic [3:0] m, input logic [1:0] inc);
    logic [1:0] prev;
    restart(m, m);
    #5;
    prev = fetch_grant_tid;
    repeat (6) begin
      step;
      #5;
      `CHK(alloc_tid_q, prev)
      `CHK(fetch_grant_tid, prev + inc)
      prev = fetch_grant_tid;
    end
  endtask
  // Only thread 0 fetches; its share of the reorder buffer must bound it
  task automatic t_partition(input logic [3:0] m, input logic [6:0] lim);
    restart(m, 4'h1);
    repeat (60) step;
    `CHK(rob_used_q, lim)
    `CHK(thread_stall[0], 1'h1)
    if (m[1]) begin
      `CHK(thread_stall[1], 1'h0)
    end
  endtask
  task automatic t_commit_fwd;
    restart(4'h1, 4'h0);
    retire_store = 1'h1;
    step;
    retire_store = 1'h0;
    `CHK(store_commit_q, 1'h1)
    `CHK(dcache_write_q, 1'h1)
    step;
    `CHK(store_commit_q, 1'h0)
    `CHK(dcache_write_q, 1'h0)
    for (int i = 0; i < 4; i++) begin
      {fwd_youngest, fwd_size_ok, fwd_contained, fwd_request} = {3'h7 & ~(3'h1 << i), 1'h1};
      step;
      fwd_request = 1'h0;
      step;
      `CHK(fwd_valid_q, i == 3)
    end
  endtask
  // Same class pairs show station routing and port limits
  task automatic t_dispatch;
    restart(4'h1, 4'h1);
    {uop0_class, uop1_class} = {OP_LOAD, OP_LOAD};
    repeat (3) step;
    `CHK(mem_dispatch_q, 2'h1)
    `CHK(int_load_issue_q, 1'h1)
    `CHK(dcache_reads_q, 2'h1)
    {uop0_class, uop1_class} = {OP_VLOAD, OP_VLOAD};
    step;
    `CHK(mem_dispatch_q, 2'h2)
    `CHK(int_load_issue_q, 1'h0)
    `CHK(dcache_reads_q, 2'h2)
    {uop0_class, uop1_class} = {OP_VSTD, OP_VSTD};
    repeat (2) step;
    `CHK(vec0_dispatch_q, 2'h2)
    `CHK(vec1_dispatch_q, 2'h0)
    {uop0_class, uop1_class} = {OP_MUL, OP_MUL};
    repeat (2) step;
    `CHK(int0_dispatch_q, 2'h2)
    `CHK(int1_dispatch_q, 2'h0)
  endtask
  task automatic t_lat(input op_class_t cls, input logic wide, input logic [2:0] exp);
    {uop0_class, uop_mul_wide} = {cls, wide};
    step;
    `CHK(result_latency_q, exp)
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    t_fetch_decode;
    t_bubble(4'h0, 1'h1, 3'h0, 1'h1, 1'h0, 3);
    t_bubble(4'h0, 1'h1, 3'h2, 1'h0, 1'h0, 6);
    t_bubble(4'h0, 1'h1, 3'h7, 1'h0, 1'h0, 7);
    t_bubble(4'h4, 1'h0, 3'h0, 1'h1, 1'h0, 2);
    t_bubble(4'h3, 1'h0, 3'h0, 1'h1, 1'h0, 0);
    t_bubble(4'h0, 1'h0, 3'h0, 1'h1, 1'h1, 1);
    t_rr(4'hf, 2'h1);
    t_rr(4'h5, 2'h2);
    t_partition(4'h1, 7'h48);
    t_partition(4'h3, 7'h24);
    t_partition(4'hf, 7'h12);
    t_commit_fwd;
    t_dispatch;
    restart(4'h1, 4'h1);
    t_lat(OP_ALU, 1'h0, 3'h1);
    t_lat(OP_LOAD, 1'h0, 3'h4);
    t_lat(OP_VLOAD, 1'h0, 3'h5);
    t_lat(OP_MUL, 1'h0, 3'h3);
    t_lat(OP_MUL, 1'h1, 3'h5);
    give_verdict;
  end
endmodule // tb_top

// ==== verilog/ooo_core_dispatch_scheduler.sv ====
`timescale 1ns/10ps
// How it works
// (RULE1) Fetch at most sixteen bytes each cycle
// (RULE2) Decode two instructions, 24 bytes, one uop
// (RULE3) Microcode flows insert three to seven bubbles
// (RULE4) Over three prefixes causes multicycle bubble
// (RULE5) Taken branch adds short decode delay
// (RULE6) Allocate two uops per cycle maximum
// (RULE7) Reorder buffer holds 72, stalls when full
// (RULE8) Sixteen store buffer entries, address plus data
// (RULE9) Two integer stations of twelve entries
// (RULE10) Integer stations dispatch two, out of order
// (RULE11) Memory station twelve entries, in-order dispatch
// (RULE12) Two vector stations, twenty entries each
// (RULE13) Partition structures among active threads dynamically
// (RULE14) Store address buffers reserve two per thread
// (RULE15) Cache reads two lines, writes one
// (RULE16) Integer load four cycles, vector five
// (RULE17) One integer load per cycle dispatched
// (RULE18) Stores commit after retire, one per cycle
// (RULE19) Simple integer ops one cycle latency
// (RULE20) Single multiplier, three or five cycles
// (RULE21) Store forwarding costs two cycles
// (RULE22) Vector port restrictions by operation class
// (RULE23) Forward only from youngest containing store
// (RULE24) Round-robin fair thread selection in front end
// (RULE25) Per-thread partition stall isolates threads
module ooo_core_dispatch_scheduler (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Thread activity
  input wire logic [dispatch_pkg::THREADS-1:0] thread_awake,
  // Fetch path, one request per thread
  input wire logic [dispatch_pkg::THREADS-1:0] fetch_ready,
  input wire logic [4:0] fetch_bytes,
  input wire logic [1:0] inst_count,
  input wire logic [4:0] inst0_len,
  input wire logic [4:0] inst1_len,
  input wire logic [3:0] inst0_prefixes,
  input wire logic inst0_microcoded,
  input wire logic [2:0] mseq_flow_len,
  input wire logic inst0_aligned,
  input wire logic taken_branch,
  input wire logic [3:0] uop0_class,
  input wire logic [3:0] uop1_class,
  input wire logic uop_mul_wide,
  output logic [1:0] fetch_grant_tid,
  output logic fetch_take,
  output logic [4:0] fetch_take_bytes,
  output logic [1:0] decode_take,
  // Allocate
  output logic [1:0] alloc_count_q,
  output logic [1:0] alloc_tid_q,
  output logic [3:0] thread_stall,
  // Retire and store commit
  input wire logic [1:0] retire_count,
  input wire logic [1:0] retire_tid,
  input wire logic retire_store,
  output logic store_commit_q,
  // Dispatch
  output logic [1:0] int0_dispatch_q,
  output logic [1:0] int1_dispatch_q,
  output logic [1:0] mem_dispatch_q,
  output logic [1:0] vec0_dispatch_q,
  output logic [1:0] vec1_dispatch_q,
  output logic int_load_issue_q,
  // Result timing
  output logic [2:0] result_latency_q,
  // Store forwarding
  input wire logic fwd_youngest,
  input wire logic fwd_size_ok,
  input wire logic fwd_contained,
  input wire logic fwd_request,
  output logic fwd_valid_q,
  // Data cache port counts
  output logic [1:0] dcache_reads_q,
  output logic dcache_write_q,
  // Occupancy
  output logic [6:0] rob_used_q
);
  import dispatch_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Thread partitioning
  logic [2:0] active_n;
  logic [6:0] rob_part;
  logic [4:0] sb_part;
  logic [6:0] rob_cnt_q [THREADS];
  logic [4:0] sab_cnt_q [THREADS];
  logic [4:0] sab_shared_used;
  logic [THREADS-1:0] stall_vec;

  always_comb begin
    active_n = 3'h0;
    for (int i = 0; i < THREADS; i++) begin
      active_n = active_n + {2'h0, thread_awake[i]};
    end
    // Hard split tracks wake and sleep; three awake rounds up to four ways
    case (active_n)
      3'h1: begin
        rob_part = 7'(ROB_SIZE);
        sb_part = 5'(STORE_BUF);
      end
      3'h2: begin
        rob_part = 7'(ROB_SIZE / 2);
        sb_part = 5'(STORE_BUF / 2);
      end
      default: begin
        rob_part = 7'(ROB_SIZE / 4);
        sb_part = 5'(STORE_BUF / 4);
      end
    endcase // [RULE13]
  end

  always_comb begin
    sab_shared_used = 5'h0;
    for (int i = 0; i < THREADS; i++) begin
      if (sab_cnt_q[i] > 5'(SAB_RESERVED)) begin
        sab_shared_used = sab_shared_used + (sab_cnt_q[i] - 5'(SAB_RESERVED));
      end
    end
  end // [RULE14]

  ////////////////////////////////////////////////////////////////////////////
  // Round-robin front end
  logic [1:0] rr_q;
  logic [1:0] pick;
  logic pick_ok;
  logic [1:0] cand;

  always_comb begin
    pick = rr_q;
    pick_ok = 1'b0;
    cand = 2'h0;
    for (int i = 0; i < THREADS; i++) begin
      cand = rr_q + 2'(i);
      if (!pick_ok && fetch_ready[cand] && thread_awake[cand] && !stall_vec[cand]) begin
        pick = cand;
        pick_ok = 1'b1;
      end
    end // [RULE24]
  end

  fe_state_t fe_q;
  logic [2:0] bubble_q;

  always_comb begin
    fetch_grant_tid = pick;
    fetch_take = pick_ok && (fe_q == FE_RUN);
    fetch_take_bytes = (fetch_bytes > 5'(FETCH_BYTES)) ? 5'(FETCH_BYTES) : fetch_bytes; // [RULE1]
    decode_take = 2'h0;
    if (fetch_take) begin
      if (inst_count >= 2'(DECODE_WIDTH) && !inst0_microcoded &&
          ({1'b0, inst0_len} + {1'b0, inst1_len} <= 6'(DECODE_MAX_BYTES))) begin
        decode_take = 2'(DECODE_WIDTH);
      end else if (inst_count != 2'h0) begin
        decode_take = 2'h1;
      end // [RULE2]
    end
  end

  // Bubble length: aligned flows cost least; flow length adds its low two bits, misalignment adds one
  logic [2:0] mseq_bubble;
  always_comb begin
    mseq_bubble = 3'(MSEQ_BUBBLE_MIN) + mseq_flow_len[1:0] + {2'h0, ~inst0_aligned};
    if (mseq_bubble > 3'(MSEQ_BUBBLE_MAX)) begin
      mseq_bubble = 3'(MSEQ_BUBBLE_MAX);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fe_q <= FE_RUN;
      bubble_q <= 3'h0;
    end else begin
      case (fe_q)
        FE_RUN: begin
          if (fetch_take && inst0_microcoded) begin
            fe_q <= FE_BUBBLE;
            bubble_q <= mseq_bubble - 3'h1; // [RULE3]
          end else if (fetch_take && inst0_prefixes > 4'(PREFIX_LIMIT)) begin
            fe_q <= FE_BUBBLE;
            bubble_q <= 3'(PREFIX_BUBBLE - 1); // [RULE4]
          end else if (fetch_take && taken_branch) begin
            fe_q <= FE_BUBBLE;
            bubble_q <= 3'(BRANCH_BUBBLE - 1); // [RULE5]
          end
        end
        FE_BUBBLE: begin
          if (bubble_q == 3'h0) begin
            fe_q <= FE_RUN;
          end else begin
            bubble_q <= bubble_q - 3'h1;
          end
        end
        default: fe_q <= FE_RUN;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rr_q <= 2'h0;
    end else if (fetch_take) begin
      rr_q <= pick + 2'h1; // [RULE24]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Allocate, reorder buffer and store buffers
  logic is_store0;
  logic is_store1;
  logic [1:0] store_n;
  assign is_store0 = (uop0_class == OP_STA) || (uop0_class == OP_VSTD);
  assign is_store1 = (uop1_class == OP_STA) || (uop1_class == OP_VSTD);
  assign store_n = {1'b0, is_store0} + {1'b0, is_store1 && decode_take == 2'h2};

  always_comb begin
    for (int i = 0; i < THREADS; i++) begin
      // Own share full stalls only this thread
      stall_vec[i] = (rob_cnt_q[i] + 7'(DECODE_WIDTH) > rob_part) ||
                     (sab_cnt_q[i] + 5'(DECODE_WIDTH) > sb_part + 5'(SAB_RESERVED) &&
                      sab_shared_used + 5'(DECODE_WIDTH) > 5'(STORE_BUF - THREADS * SAB_RESERVED)); // [RULE25] [RULE7]
    end
  end
  assign thread_stall = stall_vec;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int t = 0; t < THREADS; t++) begin
        rob_cnt_q[t] <= 7'h0;
        sab_cnt_q[t] <= 5'h0;
      end
    end else begin
      for (int t = 0; t < THREADS; t++) begin
        rob_cnt_q[t] <= rob_cnt_q[t]
          + ((fetch_take && pick == 2'(t)) ? {5'h0, decode_take} : 7'h0)
          - ((retire_tid == 2'(t)) ? {5'h0, retire_count} : 7'h0); // [RULE6] [RULE7]
        sab_cnt_q[t] <= sab_cnt_q[t]
          + ((fetch_take && pick == 2'(t)) ? {3'h0, store_n} : 5'h0)
          - ((retire_tid == 2'(t) && retire_store && sab_cnt_q[t] != 5'h0) ? 5'(STORE_COMMIT_RATE) : 5'h0); // [RULE8]
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      alloc_count_q <= 2'h0;
      alloc_tid_q <= 2'h0;
      rob_used_q <= 7'h0;
      store_commit_q <= 1'b0;
    end else begin
      alloc_count_q <= fetch_take ? decode_take : 2'h0; // [RULE6]
      alloc_tid_q <= pick;
      rob_used_q <= rob_cnt_q[0] + rob_cnt_q[1] + rob_cnt_q[2] + rob_cnt_q[3];
      store_commit_q <= retire_store; // [RULE18]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reservation station occupancy and dispatch
  logic [4:0] int0_q, int1_q, mem_q, vec0_q, vec1_q;
  logic [1:0] in_int0, in_int1, in_mem, in_vec0, in_vec1;
  logic [1:0] d_int0, d_int1, d_mem, d_vec0, d_vec1;
  logic [1:0] int_loads;

  function automatic logic [1:0] min2(input logic [4:0] v);
    min2 = (v >= 5'h2) ? 2'h2 : v[1:0];
  endfunction

  always_comb begin
    in_int0 = 2'h0; in_int1 = 2'h0; in_mem = 2'h0; in_vec0 = 2'h0; in_vec1 = 2'h0;
    int_loads = 2'h0;
    for (int i = 0; i < DECODE_WIDTH; i++) begin
      if (fetch_take && decode_take > 2'(i)) begin
        case (op_class_t'((i == 0) ? uop0_class : uop1_class))
          OP_ALU: if (i == 0) in_int0 = in_int0 + 2'h1; else in_int1 = in_int1 + 2'h1;
          OP_MUL: in_int0 = in_int0 + 2'h1; // [RULE20]
          OP_LOAD, OP_STA, OP_VLOAD, OP_PREF: in_mem = in_mem + 2'h1;
          OP_VSTD, OP_V2I: in_vec0 = in_vec0 + 2'h1; // [RULE22]
          OP_VSPEC: in_vec1 = in_vec1 + 2'h1; // [RULE22]
          default: if (i == 0) in_vec0 = in_vec0 + 2'h1; else in_vec1 = in_vec1 + 2'h1;
        endcase
      end
    end
    d_int0 = min2(int0_q); // [RULE10] [RULE19]
    d_int1 = min2(int1_q);
    // Memory station stays in order; an integer load pair is cut to one
    d_mem = min2(mem_q); // [RULE11]
    if (d_mem == 2'h2 && uop0_class == OP_LOAD && uop1_class == OP_LOAD) begin
      d_mem = 2'h1; // [RULE17]
    end
    int_loads = (uop0_class == OP_LOAD && d_mem != 2'h0) ? 2'h1 : 2'h0;
    d_vec0 = min2(vec0_q); // [RULE12]
    d_vec1 = min2(vec1_q);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      int0_q <= 5'h0; int1_q <= 5'h0; mem_q <= 5'h0; vec0_q <= 5'h0; vec1_q <= 5'h0;
    end else begin
      int0_q <= (int0_q + in_int0 - d_int0 > 5'(INT_RS_SIZE)) ? 5'(INT_RS_SIZE) : int0_q + in_int0 - d_int0; // [RULE9]
      int1_q <= (int1_q + in_int1 - d_int1 > 5'(INT_RS_SIZE)) ? 5'(INT_RS_SIZE) : int1_q + in_int1 - d_int1; // [RULE9]
      mem_q <= (mem_q + in_mem - d_mem > 5'(MEM_RS_SIZE)) ? 5'(MEM_RS_SIZE) : mem_q + in_mem - d_mem; // [RULE11]
      vec0_q <= (vec0_q + in_vec0 - d_vec0 > 5'(VEC_RS_SIZE)) ? 5'(VEC_RS_SIZE) : vec0_q + in_vec0 - d_vec0; // [RULE12]
      vec1_q <= (vec1_q + in_vec1 - d_vec1 > 5'(VEC_RS_SIZE)) ? 5'(VEC_RS_SIZE) : vec1_q + in_vec1 - d_vec1; // [RULE12]
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      int0_dispatch_q <= 2'h0; int1_dispatch_q <= 2'h0; mem_dispatch_q <= 2'h0;
      vec0_dispatch_q <= 2'h0; vec1_dispatch_q <= 2'h0; int_load_issue_q <= 1'b0;
      dcache_reads_q <= 2'h0; dcache_write_q <= 1'b0;
    end else begin
      int0_dispatch_q <= d_int0;
      int1_dispatch_q <= d_int1;
      mem_dispatch_q <= d_mem;
      vec0_dispatch_q <= d_vec0;
      vec1_dispatch_q <= d_vec1;
      int_load_issue_q <= int_loads[0]; // [RULE17]
      dcache_reads_q <= (d_mem > 2'(CACHE_READS)) ? 2'(CACHE_READS) : d_mem; // [RULE15]
      dcache_write_q <= retire_store && CACHE_WRITES != 0; // [RULE15] [RULE18]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Latency and forwarding
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      result_latency_q <= 3'h0;
    end else begin
      case (op_class_t'(uop0_class))
        OP_ALU: result_latency_q <= 3'(LAT_SIMPLE); // [RULE19]
        OP_MUL: result_latency_q <= uop_mul_wide ? 3'(LAT_MUL_LONG) : 3'(LAT_MUL_SHORT); // [RULE20]
        OP_LOAD: result_latency_q <= 3'(LAT_INT_LOAD); // [RULE16]
        OP_VLOAD: result_latency_q <= 3'(LAT_VEC_LOAD); // [RULE16]
        default: result_latency_q <= 3'h0;
      endcase
    end
  end

  // Forward result appears after the fixed two-cycle cost
  logic [LAT_FORWARD-1:0] fwd_pipe_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fwd_pipe_q <= '0;
    end else begin
      fwd_pipe_q <= {fwd_pipe_q[LAT_FORWARD-2:0], fwd_request && fwd_youngest && fwd_size_ok && fwd_contained}; // [RULE23] [RULE21]
    end
  end
  assign fwd_valid_q = fwd_pipe_q[LAT_FORWARD-1];
endmodule // ooo_core_dispatch_scheduler
